// ---- verilog/tpo_pkg.sv ----
// package: constants and carrier types for the timed pulse output channel
package tpo_pkg;
   // timing
   localparam int unsigned CLK_HZ          = 40000000;
   localparam int unsigned TICK_US         = 10;
   localparam int unsigned TICK_CYC        = (CLK_HZ / 1000000) * TICK_US;
   localparam int unsigned TRIG_LAT_MS     = 10;
   localparam int unsigned TRIG_LAT_CYC    = (CLK_HZ / 1000) * TRIG_LAT_MS;
   localparam int unsigned TICK_CNT_W      = 9;
   localparam int unsigned DUR_W           = 24;
   localparam int unsigned PCT_W           = 7;
   localparam int unsigned PWM_STEPS       = 100;
   // one pulse of 1.0 s in 10 us ticks
   localparam logic [23:0] DUR_FIXED_RST   = 24'h0186A0;
   localparam logic [23:0] PR_DELAY_RST    = 24'h00C350;
   localparam logic [6:0]  PR_DUTY_RST     = 7'h32;
   localparam logic        SC_EN_RST       = 1'b1;
   localparam logic        PR_EN_RST       = 1'b1;
   localparam logic        INV_RST         = 1'b0;

   typedef enum logic [2:0] {
      TPO_MODE_NONE,
      TPO_MODE_ONOFF,
      TPO_MODE_THRESH,
      TPO_MODE_PWM_FAST,
      TPO_MODE_PWM_SLOW,
      TPO_MODE_FREQ_MOD,
      TPO_MODE_PULSE,
      TPO_MODE_DOSING
   } tpo_mode_t;

   typedef struct packed {
      tpo_mode_t   mode;
      logic        dur_from_net;
      logic [23:0] dur_fixed;
      logic        indep_input;
      logic        err_on_level;
      logic        sc_en;
      logic        invert;
      logic        pr_en;
      logic [23:0] pr_delay;
      logic [6:0]  pr_duty;
   } tpo_cfg_t;

   typedef struct packed {
      logic        trig_own;
      logic        trig_field_bit;
      logic [23:0] dur_net;
      logic        man_set;
      logic        man_cancel;
   } tpo_cmd_t;
endpackage

// ---- verilog/tpo_tick_gen.sv ----
// 10 us time base, independent of any communication cycle
module tpo_tick_gen (
   input  wire logic clk_sys,
   input  wire logic rst,
   input  wire logic ce,
   output logic      tick
);
   logic [tpo_pkg::TICK_CNT_W-1:0] cnt_reg;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cnt_reg <= '0;
         tick    <= 1'b0;
      end else if (ce) begin
         if (cnt_reg == tpo_pkg::TICK_CNT_W'(tpo_pkg::TICK_CYC - 1)) begin
            cnt_reg <= '0;
            tick    <= 1'b1;
         end else begin
            cnt_reg <= cnt_reg + 1'b1;
            tick    <= 1'b0;
         end
      end
   end
endmodule

// ---- verilog/tpo_pwm.sv ----
// power reduction pwm: 100 steps of one tick, duty in percent
module tpo_pwm (
   input  wire logic                     clk_sys,
   input  wire logic                     rst,
   input  wire logic                     ce,
   input  wire logic                     tick,
   input  wire logic [tpo_pkg::PCT_W-1:0] duty,
   output logic                          pwm
);
   logic [tpo_pkg::PCT_W-1:0] step_reg;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         step_reg <= '0;
      end else if (ce && tick) begin
         if (step_reg == tpo_pkg::PCT_W'(tpo_pkg::PWM_STEPS - 1)) begin
            step_reg <= '0;
         end else begin
            step_reg <= step_reg + 1'b1;
         end
      end
   end

   // duty above 100 saturates to steady on
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pwm <= 1'b0;
      end else if (ce) begin
         pwm <= (step_reg < duty);
      end
   end
endmodule

// ---- verilog/tpo_channel.sv ----
// one timed pulse output channel: trigger, override, cancel, error, short, inversion, power reduction
// What this block does
// - rising trigger edge starts an output pulse of configured duration
// - trigger edges during an active output are ignored
// - manual set holds output active as long as it lasts
// - manual set during a pulse cancels it; output drops when override ends
// - cancel drops output at once unless error_in sets the error level, aborts pulse, beats trigger and set
// - trigger to output latency stays below 10 ms
// - pulse timed by dedicated 10 us internal timer
// - pulse duration comes from fixed setting or network value per channel
// - independent input picks own trigger or shared bit field bit
// - on error output goes to the configured error level
// - detected short with detection enabled ends pulse and flags fault
// - inversion drives pin opposite to logical output
// - after continuous on for delay, power reduction substitutes pwm
// - power reduction set by delay and duty percentage
// - seven modes, unconfigured after reset, pwm fast and slow
// - defaults: short detection and power reduction on, inversion off
module tpo_channel (
   input  wire logic              clk_sys,
   input  wire logic              rst,
   input  wire logic              ce,
   input  wire tpo_pkg::tpo_cfg_t cfg,
   input  wire logic              cfg_load,
   input  wire tpo_pkg::tpo_cmd_t cmd,
   input  wire logic              error_in,
   input  wire logic              short_in,
   input  wire logic              short_clr,
   output logic                   out_pin,
   output logic                   out_logic,
   output logic                   short_flag,
   output logic                   pulse_busy,
   output logic                   reduced,
   output logic                   configured
);
   typedef enum logic [1:0] {
      TPO_ST_IDLE,
      TPO_ST_PULSE,
      TPO_ST_HOLD
   } tpo_state_t;

   tpo_pkg::tpo_cfg_t          cfg_reg;
   tpo_state_t                 state_reg;
   tpo_state_t                 state_next;
   logic [tpo_pkg::DUR_W-1:0]  dur_cnt_reg;
   logic [tpo_pkg::DUR_W-1:0]  dur_lat_reg;
   logic [tpo_pkg::DUR_W-1:0]  on_cnt_reg;
   logic [2:0]                 trig_sync_reg;
   logic [2:0]                 short_sync_reg;
   logic                       trig_reg;
   logic                       trig_prev_reg;
   logic                       short_reg;
   logic                       tick;
   logic                       pwm;
   logic                       trig_sel;
   logic                       trig_rise;
   logic                       timed_mode;
   logic                       short_hit;
   logic                       logic_on;
   logic                       drive_on;

   tpo_tick_gen u_tick (
      .clk_sys (clk_sys),
      .rst     (rst),
      .ce      (ce),
      .tick    (tick)
   );

   tpo_pwm u_pwm (
      .clk_sys (clk_sys),
      .rst     (rst),
      .ce      (ce),
      .tick    (tick),
      .duty    (cfg_reg.pr_duty),
      .pwm     (pwm)
   );

   // configuration store with defaults; mode starts unconfigured
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cfg_reg.mode         <= tpo_pkg::TPO_MODE_NONE;
         cfg_reg.dur_from_net <= 1'b0;
         cfg_reg.dur_fixed    <= tpo_pkg::DUR_FIXED_RST;
         cfg_reg.indep_input  <= 1'b0;
         cfg_reg.err_on_level <= 1'b0;
         cfg_reg.sc_en        <= tpo_pkg::SC_EN_RST;
         cfg_reg.invert       <= tpo_pkg::INV_RST;
         cfg_reg.pr_en        <= tpo_pkg::PR_EN_RST;
         cfg_reg.pr_delay     <= tpo_pkg::PR_DELAY_RST;
         cfg_reg.pr_duty      <= tpo_pkg::PR_DUTY_RST;
      end else if (ce && cfg_load) begin
         cfg_reg <= cfg;
      end
   end

   assign timed_mode = (cfg_reg.mode == tpo_pkg::TPO_MODE_PULSE) ||
                       (cfg_reg.mode == tpo_pkg::TPO_MODE_DOSING);

   // trigger source choice happens before synchronising so one chain suffices
   assign trig_sel = cfg_reg.indep_input ? cmd.trig_own : cmd.trig_field_bit;

   // three-stage pin synchronisers, change taken when stages two and three agree
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         trig_sync_reg  <= '0;
         short_sync_reg <= '0;
         trig_reg       <= 1'b0;
         short_reg      <= 1'b0;
         trig_prev_reg  <= 1'b0;
      end else if (ce) begin
         trig_sync_reg  <= {trig_sync_reg[1:0], trig_sel};
         short_sync_reg <= {short_sync_reg[1:0], short_in};
         if (trig_sync_reg[1] == trig_sync_reg[2]) begin
            trig_reg <= trig_sync_reg[2];
         end
         if (short_sync_reg[1] == short_sync_reg[2]) begin
            short_reg <= short_sync_reg[2];
         end
         trig_prev_reg <= trig_reg;
      end
   end

   assign trig_rise = trig_reg && !trig_prev_reg;
   assign short_hit = short_reg && cfg_reg.sc_en;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         TPO_ST_IDLE: begin
            if (cmd.man_set) begin
               state_next = TPO_ST_HOLD;
            end else if (trig_rise && timed_mode && !error_in && !short_hit) begin
               state_next = TPO_ST_PULSE;
            end
         end
         TPO_ST_PULSE: begin
            // further edges not looked at here
            if (cmd.man_set) begin
               state_next = TPO_ST_HOLD;
            end else if (short_hit) begin
               state_next = TPO_ST_IDLE;
            end else if (tick && (dur_cnt_reg + 1'b1 >= dur_lat_reg)) begin
               state_next = TPO_ST_IDLE;
            end
         end
         TPO_ST_HOLD: begin
            if (!cmd.man_set) begin
               state_next = TPO_ST_IDLE;
            end
         end
      endcase
      if (cmd.man_cancel || error_in) begin
         state_next = TPO_ST_IDLE;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_reg <= TPO_ST_IDLE;
      end else if (ce) begin
         state_reg <= state_next;
      end
   end

   // duration is latched at start so a network update cannot stretch a running pulse
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         dur_cnt_reg <= '0;
         dur_lat_reg <= '0;
      end else if (ce) begin
         if (state_reg != TPO_ST_PULSE) begin
            dur_cnt_reg <= '0;
            dur_lat_reg <= cfg_reg.dur_from_net ? cmd.dur_net : cfg_reg.dur_fixed;
         end else if (tick) begin
            dur_cnt_reg <= dur_cnt_reg + 1'b1;
         end
      end
   end

   assign logic_on = error_in ? cfg_reg.err_on_level
                              : (state_next != TPO_ST_IDLE);

   // continuous on-time; short pulses restart it so reduction may never engage
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         on_cnt_reg <= '0;
      end else if (ce) begin
         if (!out_logic) begin
            on_cnt_reg <= '0;
         end else if (tick && (on_cnt_reg != cfg_reg.pr_delay)) begin
            on_cnt_reg <= on_cnt_reg + 1'b1;
         end
      end
   end

   assign drive_on = (reduced && logic_on) ? pwm : logic_on;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         out_logic  <= 1'b0;
         out_pin    <= 1'b0;
         reduced    <= 1'b0;
         pulse_busy <= 1'b0;
         configured <= 1'b0;
      end else if (ce) begin
         out_logic  <= logic_on;
         out_pin    <= drive_on ^ cfg_reg.invert;
         reduced    <= cfg_reg.pr_en && out_logic && logic_on &&
                       (on_cnt_reg == cfg_reg.pr_delay);
         pulse_busy <= (state_next == TPO_ST_PULSE);
         configured <= (cfg_reg.mode != tpo_pkg::TPO_MODE_NONE);
      end
   end

   // sticky fault; a new short in the clear cycle wins
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         short_flag <= 1'b0;
      end else if (ce) begin
         if (short_hit && (state_reg == TPO_ST_PULSE)) begin
            short_flag <= 1'b1;
         end else if (short_clr) begin
            short_flag <= 1'b0;
         end
      end
   end
endmodule

// ---- bench/tpo_asserts.sv ----
// port-level checker for the timed pulse output channel
module tpo_asserts #(
   parameter int unsigned MAX_TICKS = 4
) (
   input wire logic              clk_sys,
   input wire logic              rst,
   input wire logic              ce,
   input wire tpo_pkg::tpo_cfg_t cfg,
   input wire logic              cfg_load,
   input wire tpo_pkg::tpo_cmd_t cmd,
   input wire logic              error_in,
   input wire logic              short_in,
   input wire logic              short_clr,
   input wire logic              out_pin,
   input wire logic              out_logic,
   input wire logic              short_flag,
   input wire logic              pulse_busy,
   input wire logic              reduced,
   input wire logic              configured
);
   timeunit 1ns;
   timeprecision 100ps;
   // two extra ticks of slack for the free-running tick phase
   localparam int unsigned BUSY_MAX = (MAX_TICKS + 2) * 400;
   int unsigned busy_cnt;
   always_ff @(posedge clk_sys) begin
      if (rst || !pulse_busy) busy_cnt <= 0;
      else busy_cnt <= busy_cnt + 1;
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   a_reset_clear: assert property (disable iff (1'b0) rst |=> !out_logic && !short_flag && !configured)
      else $error("outputs not cleared by reset");
   a_trig_start: assert property ($rose(cmd.trig_own) && cfg.indep_input && configured && !out_logic && !error_in
      && !short_in |-> ##[1:8] out_logic) else $error("trigger did not start pulse");
   a_pulse_bound: assert property (busy_cnt <= BUSY_MAX)
      else $error("pulse extended beyond duration");
   a_set_holds: assert property (cmd.man_set && !cmd.man_cancel && !error_in |=> out_logic)
      else $error("manual set not holding output");
   a_cancel_wins: assert property (cmd.man_cancel |=> !out_logic && !pulse_busy)
      else $error("cancel did not drop output");
   a_error_level: assert property (error_in && !cmd.man_cancel |=> out_logic == $past(cfg.err_on_level))
      else $error("error level wrong");
   a_short_ends: assert property ($rose(short_flag) |-> ##[0:1] !pulse_busy)
      else $error("short did not end pulse");
   a_pin_invert: assert property ($past(configured) && !reduced && !$past(reduced)
      |-> out_pin == (out_logic ^ cfg.invert)) else $error("pin level wrong");
   a_reduce_wait: assert property ($rose(reduced) |-> $past(out_logic, 8) && out_logic)
      else $error("reduction without long on time");
   c_pulse: cover property ($rose(pulse_busy));
   c_reduce: cover property ($rose(reduced));
   c_short: cover property ($rose(short_flag));
endmodule
bind tpo_channel tpo_asserts #(.MAX_TICKS(4)) tpo_asserts_i (.clk_sys(clk_sys), .rst(rst), .ce(ce), .cfg(cfg),
   .cfg_load(cfg_load), .cmd(cmd), .error_in(error_in), .short_in(short_in), .short_clr(short_clr),
   .out_pin(out_pin), .out_logic(out_logic), .short_flag(short_flag), .pulse_busy(pulse_busy),
   .reduced(reduced), .configured(configured));

// ---- bench/tpo_ctrl_model.sv ----
// fieldbus controller model: trigger sources, network duration, manual commands
module tpo_ctrl_model (
   input  wire logic         clk_sys,
   output tpo_pkg::tpo_cmd_t cmd
);
   timeunit 1ns;
   timeprecision 100ps;
   initial cmd = '{1'b0, 1'b0, 24'h000002, 1'b0, 1'b0};
   // edge is dropped again before return, so each call makes a fresh rising edge
   task trig(input logic field);
      if (field) cmd.trig_field_bit = 1'b1;
      else cmd.trig_own = 1'b1;
      repeat (8) @(negedge clk_sys);
      cmd.trig_own = 1'b0;
      cmd.trig_field_bit = 1'b0;
      repeat (8) @(negedge clk_sys);
   endtask
   task man(input logic set, input logic cancel);
      cmd.man_set = set;
      cmd.man_cancel = cancel;
   endtask
endmodule

// ---- bench/tb.sv ----
// self-checking bench for the timed pulse output channel
module tb;
   timeunit 1ns;
   timeprecision 100ps;
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
   $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, a, b); end end
   logic              clk_sys = 1'b0;
   logic              rst = 1'b1;
   logic              ce = 1'b1;
   tpo_pkg::tpo_cfg_t cfg = '{tpo_pkg::TPO_MODE_PULSE, 1'b0, 24'h000003, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1,
                              24'h000002, 7'h32};
   logic              cfg_load = 1'b0;
   tpo_pkg::tpo_cmd_t cmd;
   logic              error_in = 1'b0;
   logic              short_in = 1'b0;
   logic              short_clr = 1'b0;
   logic              out_pin, out_logic, short_flag, pulse_busy, reduced, configured;
   logic              saw_red = 1'b0;
   int                n_mismatch = 0;
   int                n_tests = 0;
   int                t;
   always #12.5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (reduced === 1'b1) saw_red <= 1'b1;
   tpo_ctrl_model tpo_ctrl_model_i (.clk_sys(clk_sys), .cmd(cmd));
   tpo_channel tpo_channel_i (.clk_sys(clk_sys), .rst(rst), .ce(ce), .cfg(cfg), .cfg_load(cfg_load), .cmd(cmd),
      .error_in(error_in), .short_in(short_in), .short_clr(short_clr), .out_pin(out_pin), .out_logic(out_logic),
      .short_flag(short_flag), .pulse_busy(pulse_busy), .reduced(reduced), .configured(configured));
   task stop_test;
      $display("mismatches=%0d checks=%0d", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task wait_out(input logic v, input int lim);
      t = 0;
      while (out_logic !== v && t < lim) begin
         cyc(1);
         t++;
      end
      if (t >= lim) begin
         n_mismatch++;
         stop_test();
      end
   endtask
   task load(input logic net, input logic indep);
      cfg.dur_from_net = net;
      cfg.indep_input = indep;
      cfg_load = 1'b1;
      cyc(1);
      cfg_load = 1'b0;
      cyc(2);
   endtask
   // on-time may be short of the set ticks by up to one tick of phase, plus the retrigger call
   task pulse(input logic field, input int ticks);
      tpo_ctrl_model_i.trig(field);
      wait_out(1'b1, 20);
      tpo_ctrl_model_i.trig(field);
      wait_out(1'b0, (ticks + 2) * 400);
      `CHK(t > (ticks - 1) * 400 - 40 && t <= (ticks + 1) * 400, 1'b1)
   endtask
   initial begin
      cyc(20);
      rst = 1'b0;
      cyc(1);
      `CHK({out_pin, out_logic, short_flag, configured}, 4'h0)
      load(1'b0, 1'b1);
      `CHK({configured, out_pin}, 2'h3)
      pulse(1'b0, 3);
      `CHK(saw_red, 1'b1)
      load(1'b1, 1'b0);
      pulse(1'b1, 2);
      tpo_ctrl_model_i.trig(1'b1);
      tpo_ctrl_model_i.man(1'b1, 1'b0);
      cyc(1400);
      `CHK(out_logic, 1'b1)
      tpo_ctrl_model_i.man(1'b0, 1'b0);
      cyc(2);
      `CHK({out_logic, pulse_busy}, 2'h0)
      tpo_ctrl_model_i.trig(1'b1);
      tpo_ctrl_model_i.man(1'b1, 1'b1);
      cyc(1);
      `CHK({out_logic, pulse_busy}, 2'h0)
      tpo_ctrl_model_i.man(1'b0, 1'b0);
      error_in = 1'b1;
      cyc(2);
      `CHK({out_logic, pulse_busy}, 2'h2)
      error_in = 1'b0;
      cyc(2);
      tpo_ctrl_model_i.trig(1'b1);
      short_in = 1'b1;
      cyc(8);
      `CHK({short_flag, pulse_busy, out_logic}, 3'h4)
      short_in = 1'b0;
      cyc(6);
      short_clr = 1'b1;
      cyc(1);
      short_clr = 1'b0;
      cyc(1);
      `CHK(short_flag, 1'b0)
      stop_test();
   end
endmodule
